// file: rtl/cmd_decoder.v
// command interpreter of the cell monitor: frame check, code decode, poll output
`timescale 1ns/10ps
`include "cmd_decode_map.vh"
module cmd_decoder (
  // clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // received command frame from the link shifter
  input  wire        frame_valid,
  input  wire [7:0]  command_first_byte,
  input  wire [7:0]  command_second_byte,
  input  wire [15:0] packet_error_code,
  // device pins
  input  wire [3:0]  addr_pins,
  input  wire        chip_select_n,
  input  wire        converter_busy,
  // decoded action, one-cycle strobe with fields
  output reg         action_valid_q,
  output reg  [4:0]  action_q,
  output reg  [3:0]  read_group_q,
  output reg  [1:0]  converter_speed_select_q,
  output reg  [5:0]  cell_select_q,
  output reg         test_current_direction_q,
  output reg  [1:0]  self_test_pattern_q,
  output reg  [2:0]  auxiliary_select_q,
  output reg  [2:0]  health_select_q,
  output reg         start_conversion_q,
  // frame status
  output reg         pec_error_q,
  output reg         rejected_q,
  // serial output while polling
  output reg         serial_out_q
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  wire [3:0] addr_s;
  wire       cs_n_s;
  wire       busy_s;

  sync2 #(.WIDTH(6)) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     ({addr_pins, chip_select_n, converter_busy}),
    .dout    ({addr_s, cs_n_s, busy_s})
  );

  // ----------------------------------------
  // frame check
  // ----------------------------------------
  wire [15:0] pec_exp;
  wire [10:0] code;
  wire        bcast;
  wire        addr_hit;
  wire        pec_ok;

  pec_calc u_pec (
    .data ({command_first_byte, command_second_byte}),
    .pec  (pec_exp)
  );

  assign code     = {command_first_byte[2:0], command_second_byte};
  assign bcast    = (command_first_byte[7:3] == 5'h00);
  assign addr_hit = command_first_byte[7] && (command_first_byte[6:3] == addr_s);
  assign pec_ok   = (packet_error_code == pec_exp);

  // ----------------------------------------
  // code decode
  // ----------------------------------------
  // returns {action, legal}; legal clear means nothing is started
  function [5:0] decode;
    input [10:0] c;
    reg   [4:0]  a;
    reg          ok;
    begin
      a  = `ACT_NONE;
      ok = 1'b0;
      if (c == `CMD_WRITE_CONFIG) begin
        a = `ACT_WRITE_CFG;
      end else if (c == `CMD_READ_CONFIG) begin
        a = `ACT_READ_CFG;
      end else if (c >= `CMD_READ_CELL_FIRST && c <= `CMD_READ_CELL_LAST) begin
        a = `ACT_READ_CELL;
      end else if (c == `CMD_READ_AUX_A || c == `CMD_READ_AUX_B) begin
        a = `ACT_READ_AUX;
      end else if (c >= `CMD_READ_HEALTH_A && c <= `CMD_READ_HEALTH_C) begin
        a = `ACT_READ_HEALTH;
      end else if (c == `CMD_CLEAR_CELL) begin
        a = `ACT_CLEAR_CELL;
      end else if (c == `CMD_CLEAR_AUX) begin
        a = `ACT_CLEAR_AUX;
      end else if (c == `CMD_CLEAR_HEALTH) begin
        a = `ACT_CLEAR_HLTH;
      end else if (c == `CMD_POLL_BUSY) begin
        a = `ACT_POLL;
      end else if (c == `CMD_MUX_DIAG) begin
        a = `ACT_MUX_DIAG;
      // self-test low patterns are checked before the plain channel forms
      end else if (c[5:0] == `LOW_SELF_ALL && c[10] &&
                   (c[9:8] == `PAT_ONE || c[9:8] == `PAT_TWO)) begin
        a = `ACT_SELF_CELL;
      end else if (c[5:0] == `LOW_SELF_ALL && !c[10] &&
                   (c[9:8] == `PAT_ONE || c[9:8] == `PAT_TWO)) begin
        a = `ACT_SELF_HEALTH;
      end else if (c[5:0] == `LOW_SELF_GPIO && !c[10] &&
                   (c[9:8] == `PAT_ONE || c[9:8] == `PAT_TWO)) begin
        a = `ACT_SELF_GPIO;
      end else if (c[10:8] == `TOP_CELL && c[5:0] == `LOW_SUM) begin
        a = `ACT_CELL_SUM;
      end else if (c[10:8] == `TOP_CELL) begin
        a = `ACT_CONV_CELL;
      end else if (c[10:9] == 2'h3) begin
        a = `ACT_OPEN_WIRE;
      end else if (c[10:8] == `TOP_GPIO && c[5:0] == `LOW_SUM) begin
        a = `ACT_GPIO_SUM;
      end else if (c[10:8] == `TOP_GPIO && c[5:3] == `MID_GPIO) begin
        a = `ACT_CONV_GPIO;
      end else if (c[10:8] == `TOP_GPIO && c[5:3] == `MID_HEALTH) begin
        a = `ACT_CONV_HEALTH;
      end
      // invalid selections are rejected like unlisted codes
      if (a == `ACT_CONV_CELL || a == `ACT_OPEN_WIRE) begin
        ok = (c[5:0] <= `CELL_SEL_MAX);
      end else if (a == `ACT_CONV_HEALTH) begin
        ok = (c[2:0] <= `HEALTH_SEL_MAX);
      end else begin
        ok = (a != `ACT_NONE);
      end
      decode = {a, ok};
    end
  endfunction

  wire [5:0] dec;
  wire       accept;
  wire       is_conv;

  assign dec     = decode(code);
  assign accept  = frame_valid && pec_ok && (bcast || addr_hit) && dec[0];
  assign is_conv = (dec[5:1] >= `ACT_CONV_CELL);

  // ----------------------------------------
  // action register
  // ----------------------------------------
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      action_valid_q           <= 1'b0;
      action_q                 <= `ACT_NONE;
      read_group_q             <= 4'h0;
      converter_speed_select_q <= 2'h0;
      cell_select_q            <= 6'h00;
      test_current_direction_q <= 1'b0;
      self_test_pattern_q      <= 2'h0;
      auxiliary_select_q       <= 3'h0;
      health_select_q          <= 3'h0;
      start_conversion_q       <= 1'b0;
      pec_error_q              <= 1'b0;
      rejected_q               <= 1'b0;
    end else begin
      action_valid_q     <= accept;
      start_conversion_q <= accept && is_conv;
      pec_error_q        <= frame_valid && !pec_ok;
      rejected_q         <= frame_valid && pec_ok && (bcast || addr_hit) && !dec[0];
      // fields only move on an accepted command so results stay untouched
      if (accept) begin
        action_q                 <= dec[5:1];
        read_group_q             <= code[3:0];
        converter_speed_select_q <= code[7:6];
        cell_select_q            <= code[5:0];
        test_current_direction_q <= code[8];
        self_test_pattern_q      <= code[9:8];
        auxiliary_select_q       <= code[2:0];
        health_select_q          <= code[2:0];
      end
    end
  end

  // ----------------------------------------
  // poll output
  // ----------------------------------------
  // poll mode is entered by the poll code or by any conversion start
  reg polling_q;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      polling_q    <= 1'b0;
      serial_out_q <= 1'b1;
    end else begin
      if (cs_n_s) begin
        polling_q <= 1'b0;
      end else if (accept && (dec[5:1] == `ACT_POLL || is_conv)) begin
        polling_q <= 1'b1;
      end
      // two synced cycles of lag on busy; host sees low no later than three clocks after
      serial_out_q <= !(polling_q && !cs_n_s && busy_s);
    end
  end
endmodule // cmd_decoder

// file: rtl/cmd_decode_map.vh
// command code map and field layout for the cell monitor command decoder
//
// Operation
// - nine cell group read codes 0x004..0x00C return the selected group
// - auxiliary group reads use 0x010 (A) and 0x011 (B)
// - health group reads use 0x014, 0x015, 0x016 for groups A, B, C
// - clear codes 0x019 cells, 0x01A auxiliary, 0x01B health clear those results
// - poll 0x01C, mux diagnosis 0x01D, config write 0x001, config read 0x002
// - bits 10:8 = 100 start cell conversion; bits 7:6 speed, 5:0 cell select
// - cell select 0 means all, 1..36 one cell, above 36 invalid
// - bits 10:9 = 11 start open wire check; bit 8 one pulls down
// - bits 10:8 = 100 with low bits 110000 adds sum of cells
// - self tests: pattern bits 9:8, cell/gpio/health by bit 10 and low bits
// - bits 10:8 = 011, 5:3 = 100 start gpio conversion, bits 2:0 select
// - bits 10:8 = 011 with low bits 110000 start gpio plus sum conversion
// - bits 10:8 = 011, 5:3 = 101 health conversion; select above 3 invalid
// - broadcast when first byte 7:3 zero; addressed commands need address match
// - two byte error code over both command bytes checked before acting
// - after poll, serial out low while busy, high when done or deselected
`ifndef CMD_DECODE_MAP_VH
`define CMD_DECODE_MAP_VH

// ----------------------------------------
// fixed command codes
// ----------------------------------------
`define CMD_WRITE_CONFIG    11'h001
`define CMD_READ_CONFIG     11'h002
`define CMD_READ_CELL_FIRST 11'h004
`define CMD_READ_CELL_LAST  11'h00C
`define CMD_READ_AUX_A      11'h010
`define CMD_READ_AUX_B      11'h011
`define CMD_READ_HEALTH_A   11'h014
`define CMD_READ_HEALTH_C   11'h016
`define CMD_CLEAR_CELL      11'h019
`define CMD_CLEAR_AUX       11'h01A
`define CMD_CLEAR_HEALTH    11'h01B
`define CMD_POLL_BUSY       11'h01C
`define CMD_MUX_DIAG        11'h01D

// ----------------------------------------
// conversion code fields
// ----------------------------------------
`define TOP_CELL        3'h4
`define TOP_GPIO        3'h3
`define LOW_SUM         6'h30
`define LOW_SELF_ALL    6'h3F
`define LOW_SELF_GPIO   6'h37
`define MID_GPIO        3'h4
`define MID_HEALTH      3'h5
`define CELL_SEL_MAX    6'h24
`define HEALTH_SEL_MAX  3'h3
`define PAT_ONE         2'h1
`define PAT_TWO         2'h2

// ----------------------------------------
// action codes reported on the decoder output
// ----------------------------------------
`define ACT_NONE        5'h00
`define ACT_WRITE_CFG   5'h01
`define ACT_READ_CFG    5'h02
`define ACT_READ_CELL   5'h03
`define ACT_READ_AUX    5'h04
`define ACT_READ_HEALTH 5'h05
`define ACT_CLEAR_CELL  5'h06
`define ACT_CLEAR_AUX   5'h07
`define ACT_CLEAR_HLTH  5'h08
`define ACT_POLL        5'h09
`define ACT_MUX_DIAG    5'h0A
`define ACT_CONV_CELL   5'h0B
`define ACT_OPEN_WIRE   5'h0C
`define ACT_CELL_SUM    5'h0D
`define ACT_SELF_CELL   5'h0E
`define ACT_CONV_GPIO   5'h0F
`define ACT_GPIO_SUM    5'h10
`define ACT_SELF_GPIO   5'h11
`define ACT_CONV_HEALTH 5'h12
`define ACT_SELF_HEALTH 5'h13

// ----------------------------------------
// error code
// ----------------------------------------
`define PEC_SEED        16'h0010
`define PEC_POLY        16'h4599

`endif

// file: rtl/pec_calc.v
// 15-bit error code generator over a 16-bit command word
`timescale 1ns/10ps
`include "cmd_decode_map.vh"
module pec_calc (
  // command word
  input  wire [15:0] data,
  // code, shifted left with a zero lsb
  output wire [15:0] pec
);
  // ----------------------------------------
  // bitwise crc, combinational
  // ----------------------------------------
  function [15:0] crc16;
    input [15:0] d;
    reg   [15:0] r;
    reg          fb;
    integer      i;
    begin
      r = `PEC_SEED;
      for (i = 15; i >= 0; i = i - 1) begin
        fb = d[i] ^ r[14];
        r  = {r[14:0], 1'b0};
        if (fb) begin
          r = r ^ `PEC_POLY;
        end
        r[15] = 1'b0;
      end
      crc16 = {r[14:0], 1'b0};
    end
  endfunction

  assign pec = crc16(data);
endmodule // pec_calc

// file: rtl/sync2.v
// two flip-flop synchroniser for a bus of pin levels
`timescale 1ns/10ps
module sync2 #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             clk,
  input  wire             sys_rst,
  // pin side and synced side
  input  wire [WIDTH-1:0] din,
  output reg  [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] meta_q;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= {WIDTH{1'b0}};
      dout   <= {WIDTH{1'b0}};
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule // sync2

// file: testbench/host_model.sv
// host side model: builds command frames and their error code
`timescale 1ns/10ps
module host_model (
  // request from the bench
  input  wire        req,
  input  wire [4:0]  hdr,
  input  wire [10:0] code,
  input  wire        bad,
  // frame toward the decoder
  output wire        frame_valid,
  output wire [7:0]  first_byte,
  output wire [7:0]  second_byte,
  output wire [15:0] pec
);
  function [14:0] crc15(input [15:0] d);
    integer i;
    begin
      crc15 = 15'h0010;
      for (i = 15; i >= 0; i = i - 1) begin
        crc15 = {crc15[13:0], 1'b0} ^ ((d[i] ^ crc15[14]) ? 15'h4599 : 15'h0000);
      end
    end
  endfunction
  assign frame_valid = req;
  // outside a frame the bytes show the inverse, so stale data never looks valid
  assign first_byte  = req ? {hdr, code[10:8]} : ~{hdr, code[10:8]};
  assign second_byte = req ? code[7:0] : ~code[7:0];
  // a bad frame flips one error code bit, the smallest fault a check must catch
  assign pec = {crc15({hdr, code}), 1'b0} ^ {14'h0000, bad, 1'b0};
endmodule // host_model

// file: testbench/cmd_decoder_properties.sv
// assertion checker on the command decoder ports
`timescale 1ns/10ps
`include "cmd_decode_map.vh"
module cmd_decoder_properties (
  // clock and reset
  input wire       clk,
  input wire       sys_rst,
  // frame and pins
  input wire       frame_valid,
  input wire [7:0] command_first_byte,
  input wire [7:0] command_second_byte,
  input wire       chip_select_n,
  // decoded outputs
  input wire       action_valid_q,
  input wire [4:0] action_q,
  input wire [3:0] read_group_q,
  input wire [1:0] converter_speed_select_q,
  input wire [5:0] cell_select_q,
  input wire       start_conversion_q,
  input wire       pec_error_q,
  input wire       rejected_q,
  input wire       serial_out_q
);
  wire [10:0] code = {command_first_byte[2:0], command_second_byte};
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_accept_cause: assert property (action_valid_q |-> $past(frame_valid))
    else $error("accept without a frame");
  a_start_conv: assert property (start_conversion_q |-> action_valid_q && action_q >= `ACT_CONV_CELL)
    else $error("start without a conversion command");
  a_conv_starts: assert property (action_valid_q && action_q >= `ACT_CONV_CELL |-> start_conversion_q)
    else $error("conversion accepted without start");
  a_pec_alone: assert property (pec_error_q |-> !action_valid_q && !rejected_q)
    else $error("bad frame was acted on");
  a_cell_read: assert property (action_valid_q && action_q == `ACT_READ_CELL |->
    read_group_q == $past(command_second_byte[3:0]) && $past(code) >= 11'h004 && $past(code) <= 11'h00C)
    else $error("cell group read mismatch");
  a_poll_code: assert property (action_valid_q && $past(code) == 11'h01C |-> action_q == `ACT_POLL)
    else $error("poll code decoded wrongly");
  a_cell_fields: assert property (action_valid_q && action_q == `ACT_CONV_CELL |->
    cell_select_q <= 6'h24 && converter_speed_select_q == $past(command_second_byte[7:6]))
    else $error("cell conversion fields wrong");
  a_reject_hold: assert property (rejected_q |-> $stable(cell_select_q) && !start_conversion_q)
    else $error("rejected command changed state");
  a_deselect_high: assert property (chip_select_n [*4] |-> serial_out_q)
    else $error("serial out low while deselected");
endmodule // cmd_decoder_properties

// file: testbench/tb.sv
// self-checking bench for the command decoder
`timescale 1ns/10ps
`include "cmd_decode_map.vh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
  reg         clk = 1'b0, sys_rst = 1'b1, req = 1'b0, bad = 1'b0, chip_select_n = 1'b1, converter_busy = 1'b0;
  reg  [4:0]  hdr = 5'h00;
  reg  [10:0] code = 11'h000;
  reg  [3:0]  addr_pins = 4'h5;
  wire        frame_valid, action_valid_q, test_current_direction_q, start_conversion_q;
  wire        pec_error_q, rejected_q, serial_out_q;
  wire [7:0]  command_first_byte, command_second_byte;
  wire [15:0] packet_error_code;
  wire [4:0]  action_q;
  wire [3:0]  read_group_q;
  wire [1:0]  converter_speed_select_q, self_test_pattern_q;
  wire [5:0]  cell_select_q;
  wire [2:0]  auxiliary_select_q, health_select_q;
  integer     mismatches = 0, checks_done = 0, i;
  localparam [2:0] ACC = 3'h4, REJ = 3'h2, BAD = 3'h1, NON = 3'h0;
  always #5 clk = ~clk;
  host_model host (.req(req), .hdr(hdr), .code(code), .bad(bad), .frame_valid(frame_valid),
    .first_byte(command_first_byte), .second_byte(command_second_byte), .pec(packet_error_code));
  cmd_decoder DUT (.clk(clk), .sys_rst(sys_rst), .frame_valid(frame_valid), .command_first_byte(command_first_byte),
    .command_second_byte(command_second_byte), .packet_error_code(packet_error_code), .addr_pins(addr_pins),
    .chip_select_n(chip_select_n), .converter_busy(converter_busy), .action_valid_q(action_valid_q),
    .action_q(action_q), .read_group_q(read_group_q), .converter_speed_select_q(converter_speed_select_q),
    .cell_select_q(cell_select_q), .test_current_direction_q(test_current_direction_q),
    .self_test_pattern_q(self_test_pattern_q), .auxiliary_select_q(auxiliary_select_q),
    .health_select_q(health_select_q), .start_conversion_q(start_conversion_q), .pec_error_q(pec_error_q),
    .rejected_q(rejected_q), .serial_out_q(serial_out_q));
  // expected action of the fixed codes, unlisted ones give none
  function [4:0] fixed_act(input [10:0] c);
    if (c >= 11'h004 && c <= 11'h00C) fixed_act = `ACT_READ_CELL;
    else if (c == 11'h010 || c == 11'h011) fixed_act = `ACT_READ_AUX;
    else if (c >= 11'h014 && c <= 11'h016) fixed_act = `ACT_READ_HEALTH;
    else if (c >= 11'h019 && c <= 11'h01D) fixed_act = `ACT_CLEAR_CELL + c[2:0] - 5'h01;
    else if (c == 11'h001) fixed_act = `ACT_WRITE_CFG;
    else if (c == 11'h002) fixed_act = `ACT_READ_CFG;
    else fixed_act = `ACT_NONE;
  endfunction
  task send(input [4:0] h, input [10:0] c, input b, input [2:0] flags, input [4:0] act);
    begin
      @(posedge clk);
      hdr <= h;
      code <= c;
      bad <= b;
      req <= 1'b1;
      @(posedge clk);
      req <= 1'b0;
      #1;
      `CHK({action_valid_q, rejected_q, pec_error_q}, flags)
      if (flags[2]) `CHK(action_q, act)
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  initial begin
    #20000;
    mismatches = mismatches + 1;
    wrap_up;
  end
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    for (i = 0; i < 32; i = i + 1) begin
      send(5'h00, i[10:0], 1'b0, (fixed_act(i[10:0]) == `ACT_NONE) ? REJ : ACC, fixed_act(i[10:0]));
      if (fixed_act(i[10:0]) == `ACT_READ_CELL) `CHK(read_group_q, i[3:0])
    end
    $display("test fixed codes done");
    send(5'h00, 11'h4C0, 1'b0, ACC, `ACT_CONV_CELL);
    `CHK({converter_speed_select_q, cell_select_q, start_conversion_q}, 9'h181)
    send(5'h00, 11'h424, 1'b0, ACC, `ACT_CONV_CELL);
    send(5'h00, 11'h425, 1'b0, REJ, `ACT_NONE);
    `CHK({cell_select_q, start_conversion_q}, 7'h48)
    send(5'h00, 11'h6C5, 1'b0, ACC, `ACT_OPEN_WIRE);
    `CHK(test_current_direction_q, 1'b0)
    send(5'h00, 11'h7C5, 1'b0, ACC, `ACT_OPEN_WIRE);
    `CHK({test_current_direction_q, cell_select_q}, 7'h45)
    send(5'h00, 11'h470, 1'b0, ACC, `ACT_CELL_SUM);
    send(5'h00, 11'h57F, 1'b0, ACC, `ACT_SELF_CELL);
    `CHK(self_test_pattern_q, 2'h1)
    send(5'h00, 11'h2B7, 1'b0, ACC, `ACT_SELF_GPIO);
    `CHK(self_test_pattern_q, 2'h2)
    send(5'h00, 11'h13F, 1'b0, ACC, `ACT_SELF_HEALTH);
    send(5'h00, 11'h3A2, 1'b0, ACC, `ACT_CONV_GPIO);
    `CHK({converter_speed_select_q, auxiliary_select_q}, 5'h12)
    send(5'h00, 11'h370, 1'b0, ACC, `ACT_GPIO_SUM);
    send(5'h00, 11'h32B, 1'b0, ACC, `ACT_CONV_HEALTH);
    `CHK(health_select_q, 3'h3)
    send(5'h00, 11'h32C, 1'b0, REJ, `ACT_NONE);
    $display("test conversions done");
    send(5'h15, 11'h001, 1'b0, ACC, `ACT_WRITE_CFG);
    send(5'h13, 11'h002, 1'b0, NON, `ACT_NONE);
    send(5'h00, 11'h002, 1'b1, BAD, `ACT_NONE);
    send(5'h15, 11'h360, 1'b1, BAD, `ACT_NONE);
    $display("test addressing done");
    @(posedge clk) chip_select_n <= 1'b0;
    @(posedge clk) converter_busy <= 1'b1;
    send(5'h00, 11'h01C, 1'b0, ACC, `ACT_POLL);
    repeat (5) @(posedge clk);
    #1 `CHK(serial_out_q, 1'b0)
    @(posedge clk) converter_busy <= 1'b0;
    repeat (5) @(posedge clk);
    #1 `CHK(serial_out_q, 1'b1)
    @(posedge clk) converter_busy <= 1'b1;
    send(5'h00, 11'h4C0, 1'b0, ACC, `ACT_CONV_CELL);
    repeat (5) @(posedge clk);
    #1 `CHK(serial_out_q, 1'b0)
    @(posedge clk) chip_select_n <= 1'b1;
    repeat (5) @(posedge clk);
    #1 `CHK(serial_out_q, 1'b1)
    $display("test polling done");
    wrap_up;
  end
endmodule // tb
bind cmd_decoder cmd_decoder_properties chk (.clk(clk), .sys_rst(sys_rst), .frame_valid(frame_valid),
  .command_first_byte(command_first_byte), .command_second_byte(command_second_byte), .chip_select_n(chip_select_n),
  .action_valid_q(action_valid_q), .action_q(action_q), .read_group_q(read_group_q),
  .converter_speed_select_q(converter_speed_select_q), .cell_select_q(cell_select_q),
  .start_conversion_q(start_conversion_q), .pec_error_q(pec_error_q), .rejected_q(rejected_q),
  .serial_out_q(serial_out_q));
